// File: rtl/lsecr_lane_cfg.v
/*
 * Configuration register bank for the clock lane and data lane 0: swing,
 * emphasis and equalizer codes, plus their decoded analog settings.
 * Assumes a byte-wide register port driven by the serial management
 * controller on clk: one-cycle write strobe, read data registered.
 */
// Behaviour
// - clock swing code bits 2:0, read/write, resets to 3h
// - codes 0-3: limited -15..-5%/reference, linear 800..1000/1200 mV
// - codes 4-7: limited +5..+20%; reserved in linear operation
// - clock equalizer code bits 3:0, applied only in DisplayPort mode
// - lane 0 equalizer code bits 3:0, 0h minimum to Fh maximum
// - lane 0 emphasis bits 6:4, reset 0h, dB table, 3h reserved
// - lane 0 swing bits 2:0, reset 3h, reference 1000 mV limited
// - global select bit chooses limited (0) or linear (1) swing meaning
// - per-lane swing used in limited operation only with rate select 0h
`timescale 1ns/1ps
`include "lsecr_regs.vh"

module lsecr_lane_cfg (
    input wire clk,
    input wire reset_n,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_q,
    output reg reg_hit_q,
    input wire linear_operation_select,
    input wire high_rate_active,
    input wire [1:0] high_rate_swing_select,
    input wire [1:0] legacy_rate_swing_select,
    input wire displayport_mode,
    output wire [2:0] clock_lane_swing_code,
    output wire [3:0] clock_lane_equalizer_code,
    output wire [2:0] lane0_emphasis_code,
    output wire [2:0] lane0_swing_code,
    output wire [3:0] lane0_equalizer_code,
    output reg [3:0] clock_lane_eq_applied_q,
    output reg clock_lane_eq_active_q,
    output reg [15:0] lane0_eq_strength_q,
    output reg signed [6:0] lane0_emphasis_tenth_db_q,
    output reg lane0_emphasis_reserved_q,
    output wire [11:0] clock_lane_swing_mv,
    output wire signed [5:0] clock_lane_swing_pct,
    output wire clock_lane_swing_global,
    output wire clock_lane_swing_reserved,
    output wire [11:0] lane0_swing_mv,
    output wire signed [5:0] lane0_swing_pct,
    output wire lane0_swing_global,
    output wire lane0_swing_reserved
);
    reg [7:0] clk_swing_q;
    reg [7:0] clock_lane_equalizer_code_q;
    reg [7:0] l0_swing_q;
    reg [7:0] l0_eq_q;
    reg [7:0] rdata_d;
    reg hit_d;
    reg signed [6:0] emph_d;
    wire [1:0] rate_swing_select;
    wire [15:0] eq_thermo_d;
    genvar g;

    // masking on write keeps read-only reserved bits at zero
    always @(posedge clk) begin
        if (!reset_n) begin
            clk_swing_q <= `LSECR_CLK_SWING_RST;
            clock_lane_equalizer_code_q <= `LSECR_CLOCK_LANE_EQUALIZER_CODE_RST;
            l0_swing_q <= `LSECR_L0_SWING_RST;
            l0_eq_q <= `LSECR_L0_EQ_RST;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `LSECR_CLK_SWING_OFS: clk_swing_q <= reg_wdata & `LSECR_CLK_SWING_WMASK;
                `LSECR_CLOCK_LANE_EQUALIZER_CODE_OFS: clock_lane_equalizer_code_q <= reg_wdata & `LSECR_CLOCK_LANE_EQUALIZER_CODE_WMASK;
                `LSECR_L0_SWING_OFS: l0_swing_q <= reg_wdata & `LSECR_L0_SWING_WMASK;
                `LSECR_L0_EQ_OFS: l0_eq_q <= reg_wdata & `LSECR_L0_EQ_WMASK;
                default: ;
            endcase
        end
    end

    always @* begin
        rdata_d = 8'h00;
        hit_d = 1'b1;
        case (reg_addr)
            `LSECR_CLK_SWING_OFS: rdata_d = clk_swing_q;
            `LSECR_CLOCK_LANE_EQUALIZER_CODE_OFS: rdata_d = clock_lane_equalizer_code_q;
            `LSECR_L0_SWING_OFS: rdata_d = l0_swing_q;
            `LSECR_L0_EQ_OFS: rdata_d = l0_eq_q;
            default: hit_d = 1'b0;
        endcase
    end

    // unmapped addresses read zero; other banks answer for their own range
    always @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata_q <= 8'h00;
            reg_hit_q <= 1'b0;
        end else if (reg_rd_en) begin
            reg_rdata_q <= rdata_d;
            reg_hit_q <= hit_d;
        end
    end

    assign clock_lane_swing_code = clk_swing_q[`LSECR_SWING_MSB:`LSECR_SWING_LSB];
    assign clock_lane_equalizer_code = clock_lane_equalizer_code_q[`LSECR_EQ_MSB:`LSECR_EQ_LSB];
    assign lane0_emphasis_code = l0_swing_q[`LSECR_EMPH_MSB:`LSECR_EMPH_LSB];
    assign lane0_swing_code = l0_swing_q[`LSECR_SWING_MSB:`LSECR_SWING_LSB];
    assign lane0_equalizer_code = l0_eq_q[`LSECR_EQ_MSB:`LSECR_EQ_LSB];

    // rate-specific override picks the field of the active data rate
    assign rate_swing_select = high_rate_active ? high_rate_swing_select
                                                : legacy_rate_swing_select;

    // emphasis in tenths of a dB; reserved code leaves the driver flat
    always @* begin
        case (lane0_emphasis_code)
            3'h0: emph_d = 7'sd0;
            3'h1: emph_d = 7'sd35;
            3'h2: emph_d = 7'sd60;
            3'h4: emph_d = -7'sd15;
            3'h5: emph_d = -7'sd25;
            3'h6: emph_d = -7'sd35;
            3'h7: emph_d = -7'sd48;
            default: emph_d = 7'sd0;
        endcase
    end

    // thermometer: one more stage per code step, monotone by build
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_eq_thermo
            assign eq_thermo_d[g] = (g <= lane0_equalizer_code);
        end
    endgenerate

    always @(posedge clk) begin
        if (!reset_n) begin
            clock_lane_eq_applied_q <= 4'h0;
            clock_lane_eq_active_q <= 1'b0;
            lane0_eq_strength_q <= 16'h0001;
            lane0_emphasis_tenth_db_q <= 7'sd0;
            lane0_emphasis_reserved_q <= 1'b0;
        end else begin
            clock_lane_eq_active_q <= displayport_mode;
            clock_lane_eq_applied_q <= displayport_mode ? clock_lane_equalizer_code
                                                        : 4'h0;
            lane0_emphasis_tenth_db_q <= emph_d;
            lane0_emphasis_reserved_q <= (lane0_emphasis_code == `LSECR_EMPH_RSVD);
            lane0_eq_strength_q <= eq_thermo_d;
        end
    end

    lsecr_swing_decode #(
        .LIM_REF_MV(`LSECR_CLK_LIM_REF_MV)
    ) u_clk_swing (
        .clk(clk),
        .reset_n(reset_n),
        .swing_code(clock_lane_swing_code),
        .linear_operation_select(linear_operation_select),
        .rate_swing_select(rate_swing_select),
        .swing_mv_q(clock_lane_swing_mv),
        .swing_pct_q(clock_lane_swing_pct),
        .swing_use_global_q(clock_lane_swing_global),
        .swing_reserved_q(clock_lane_swing_reserved)
    );

    lsecr_swing_decode #(
        .LIM_REF_MV(`LSECR_L0_LIM_REF_MV)
    ) u_l0_swing (
        .clk(clk),
        .reset_n(reset_n),
        .swing_code(lane0_swing_code),
        .linear_operation_select(linear_operation_select),
        .rate_swing_select(rate_swing_select),
        .swing_mv_q(lane0_swing_mv),
        .swing_pct_q(lane0_swing_pct),
        .swing_use_global_q(lane0_swing_global),
        .swing_reserved_q(lane0_swing_reserved)
    );
endmodule // lsecr_lane_cfg

// File: rtl/lsecr_regs.vh
/*
 * Register offsets, field positions, reset values and decode codes for the
 * clock lane and data lane 0 swing, emphasis and equalizer configuration.
 * Assumes an 8-bit register space reached through the device's serial
 * management port; byte offsets below are that port's sub-addresses.
 */
`ifndef LSECR_REGS_VH
`define LSECR_REGS_VH

`define LSECR_CLK_SWING_OFS 8'h12
`define LSECR_CLOCK_LANE_EQUALIZER_CODE_OFS 8'h13
`define LSECR_L0_SWING_OFS 8'h14
`define LSECR_L0_EQ_OFS 8'h15

`define LSECR_CLK_SWING_RST 8'h03
`define LSECR_CLOCK_LANE_EQUALIZER_CODE_RST 8'h00
`define LSECR_L0_SWING_RST 8'h03
`define LSECR_L0_EQ_RST 8'h00

// bits of each register that store a written value
`define LSECR_CLK_SWING_WMASK 8'h77
`define LSECR_CLOCK_LANE_EQUALIZER_CODE_WMASK 8'h0F
`define LSECR_L0_SWING_WMASK 8'h77
`define LSECR_L0_EQ_WMASK 8'h0F

`define LSECR_SWING_LSB 0
`define LSECR_SWING_MSB 2
`define LSECR_EMPH_LSB 4
`define LSECR_EMPH_MSB 6
`define LSECR_EQ_LSB 0
`define LSECR_EQ_MSB 3

`define LSECR_SWING_DEFAULT 3'h3
`define LSECR_SWING_LIN_TOP 3'h3
`define LSECR_EMPH_RSVD 3'h3
`define LSECR_RATE_SEL_LANE 2'h0

// swing in mV for the reference code of each lane, plus the linear base and step
`define LSECR_CLK_LIM_REF_MV 12'h320
`define LSECR_L0_LIM_REF_MV 12'h3E8
`define LSECR_LIN_REF_MV 12'h4B0
`define LSECR_LIN_BASE_MV 12'h320
`define LSECR_LIN_STEP_MV 12'h064

`endif

// File: rtl/lsecr_swing_decode.v
/*
 * Decodes one lane's 3-bit swing code into an analog target.
 * Assumes the linear/limited selection and rate override arrive from the
 * global control logic on the same clock; outputs are registered.
 */
`timescale 1ns/1ps
`include "lsecr_regs.vh"

module lsecr_swing_decode #(
    parameter [11:0] LIM_REF_MV = `LSECR_CLK_LIM_REF_MV
) (
    input wire clk,
    input wire reset_n,
    input wire [2:0] swing_code,
    input wire linear_operation_select,
    input wire [1:0] rate_swing_select,
    output reg [11:0] swing_mv_q,
    output reg signed [5:0] swing_pct_q,
    output reg swing_use_global_q,
    output reg swing_reserved_q
);
    reg [11:0] swing_mv_d;
    reg signed [5:0] swing_pct_d;
    reg use_global_d;
    reg reserved_d;

    always @* begin
        swing_mv_d = LIM_REF_MV;
        swing_pct_d = 6'sd0;
        use_global_d = 1'b0;
        reserved_d = 1'b0;
        if (linear_operation_select) begin
            if (swing_code == `LSECR_SWING_LIN_TOP) begin
                swing_mv_d = `LSECR_LIN_REF_MV;
            end else if (swing_code < `LSECR_SWING_LIN_TOP) begin
                swing_mv_d = `LSECR_LIN_BASE_MV
                    + `LSECR_LIN_STEP_MV * {10'h000, swing_code[1:0]};
            end else begin
                // codes above 3h have no linear meaning; drive the linear reference, 1200 mV, as code 3h does
                reserved_d = 1'b1;
                swing_mv_d = `LSECR_LIN_REF_MV;
            end
        end else if (rate_swing_select != `LSECR_RATE_SEL_LANE) begin
            use_global_d = 1'b1;
        end else begin
            // percent offset from the lane's limited reference, 5% steps
            swing_pct_d = 6'sd5 * ($signed({3'h0, swing_code}) - 6'sd3);
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            swing_mv_q <= LIM_REF_MV;
            swing_pct_q <= 6'sd0;
            swing_use_global_q <= 1'b0;
            swing_reserved_q <= 1'b0;
        end else begin
            swing_mv_q <= swing_mv_d;
            swing_pct_q <= swing_pct_d;
            swing_use_global_q <= use_global_d;
            swing_reserved_q <= reserved_d;
        end
    end
endmodule // lsecr_swing_decode

// File: sim/lsecr_lane_cfg_assertions.sv
/* checker for the lane configuration bank: stores, reads, decode timing.
   assumes it is bound to lsecr_lane_cfg, synchronous active-low reset */
`timescale 1ns/1ps
module lsecr_lane_cfg_assertions (
    input wire clk,
    input wire reset_n,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata_q,
    input wire reg_hit_q,
    input wire linear_operation_select,
    input wire displayport_mode,
    input wire [3:0] clock_lane_equalizer_code,
    input wire [2:0] lane0_emphasis_code,
    input wire [2:0] lane0_swing_code,
    input wire [3:0] clock_lane_eq_applied_q,
    input wire lane0_emphasis_reserved_q,
    input wire lane0_swing_reserved
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    lane0_cfg_store_a: assert property (reg_wr_en && reg_addr == 8'h14 |=>
        {1'b0, lane0_emphasis_code, 1'b0, lane0_swing_code} == ($past(reg_wdata) & 8'h77))
        else $error("lane0 swing or emphasis not stored");
    clock_lane_equalizer_code_store_a: assert property (reg_wr_en && reg_addr == 8'h13 |=>
        {4'h0, clock_lane_equalizer_code} == ($past(reg_wdata) & 8'h0F))
        else $error("clock equalizer code not stored");
    read_hit_map_a: assert property (reg_rd_en |=>
        reg_hit_q == ($past(reg_addr) >= 8'h12 && $past(reg_addr) <= 8'h15))
        else $error("hit flag wrong");
    lane0_readback_a: assert property (reg_rd_en && reg_addr == 8'h14 |=>
        reg_rdata_q == {1'b0, $past(lane0_emphasis_code), 1'b0, $past(lane0_swing_code)})
        else $error("lane0 readback wrong");
    rdata_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata_q))
        else $error("read data moved without read");
    eq_dp_gate_a: assert property ($past(reset_n) |-> clock_lane_eq_applied_q ==
        ($past(displayport_mode) ? $past(clock_lane_equalizer_code) : 4'h0))
        else $error("clock equalizer gating wrong");
    emph_rsvd_flag_a: assert property ($past(reset_n) |->
        lane0_emphasis_reserved_q == ($past(lane0_emphasis_code) == 3'h3))
        else $error("emphasis reserved flag wrong");
    lin_rsvd_flag_a: assert property ($past(reset_n) |-> lane0_swing_reserved ==
        ($past(linear_operation_select) && $past(lane0_swing_code) >= 3'h4))
        else $error("linear reserved flag wrong");
    cover property (reg_wr_en && reg_addr == 8'h14);
    cover property (reg_rd_en && !(reg_addr >= 8'h12 && reg_addr <= 8'h15));
    cover property (lane0_swing_reserved);
endmodule // lsecr_lane_cfg_assertions

// File: sim/tb.sv
/* self-checking bench for lsecr_lane_cfg: register access and decode.
   assumes the checker module is compiled before this file */
`timescale 1ns/1ps
module tb;
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    reg reg_wr_en = 1'b0;
    reg reg_rd_en = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg lin = 1'b0;
    reg hra = 1'b0;
    reg dpm = 1'b0;
    reg [1:0] hsel = 2'h0;
    reg [1:0] lsel = 2'h0;
    wire [7:0] rdata;
    wire hit;
    wire [3:0] eq_app;
    wire eq_act;
    wire [5:0] clk_pct;
    wire [15:0] strength;
    wire [6:0] emph_db;
    wire emph_rsvd;
    wire [11:0] clk_mv;
    wire [11:0] l0_mv;
    wire [5:0] l0_pct;
    wire l0_glob;
    wire l0_rsvd;
    integer err_total = 0;
    integer checks_done = 0;
    integer cycles = 0;
    integer i;
    localparam [55:0] EMPH = {7'h50, 7'h5D, 7'h67, 7'h71, 7'h00, 7'h3C, 7'h23, 7'h00};
    localparam [47:0] LIN_MV = {12'h4B0, 12'h3E8, 12'h384, 12'h320};
    lsecr_lane_cfg lsecr_lane_cfg_i (.clk(clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(rdata), .reg_hit_q(hit), .linear_operation_select(lin),
        .high_rate_active(hra), .high_rate_swing_select(hsel),
        .legacy_rate_swing_select(lsel), .displayport_mode(dpm),
        .clock_lane_swing_code(), .clock_lane_equalizer_code(), .lane0_emphasis_code(),
        .lane0_swing_code(), .lane0_equalizer_code(), .clock_lane_eq_applied_q(eq_app),
        .clock_lane_eq_active_q(eq_act), .lane0_eq_strength_q(strength),
        .lane0_emphasis_tenth_db_q(emph_db), .lane0_emphasis_reserved_q(emph_rsvd),
        .clock_lane_swing_mv(clk_mv), .clock_lane_swing_pct(clk_pct),
        .clock_lane_swing_global(),
        .clock_lane_swing_reserved(), .lane0_swing_mv(l0_mv), .lane0_swing_pct(l0_pct),
        .lane0_swing_global(l0_glob), .lane0_swing_reserved(l0_rsvd));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            err_total = err_total + 1;
            conclude;
        end
    end
    task conclude;
        begin
            $display("checks %0d mismatches %0d", checks_done, err_total);
            if (err_total == 0 && checks_done > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task tk(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // the idle cycle after each strobe keeps back-to-back calls from re-driving it at once
    task wr(input [7:0] a, input [7:0] d);
        begin
            reg_wr_en = 1'b1;
            reg_addr = a;
            reg_wdata = d;
            tk(1);
            reg_wr_en = 1'b0;
            tk(1);
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        begin
            reg_rd_en = 1'b1;
            reg_addr = a;
            tk(1);
            reg_rd_en = 1'b0;
            chk({15'h0, hit}, {15'h0, (a >= 8'h12 && a <= 8'h15)});
            if (a >= 8'h12 && a <= 8'h15)
                chk({8'h0, rdata}, {8'h0, exp});
            tk(1);
        end
    endtask
    initial begin
        tk(10);
        reset_n = 1'b1;
        tk(1);
        rd(8'h12, 8'h03);
        rd(8'h13, 8'h00);
        rd(8'h14, 8'h03);
        rd(8'h15, 8'h00);
        chk(strength, 16'h0001);
        chk({4'h0, clk_mv}, 16'h0320);
        for (i = 0; i < 6; i = i + 1)
            wr(8'h11 + 8'(i), 8'hFF);
        wr(8'h11, 8'h00);
        wr(8'h16, 8'h00);
        rd(8'h16, 8'h00);
        for (i = 0; i < 4; i = i + 1)
            rd(8'h12 + 8'(i), i[0] ? 8'h0F : 8'h77);
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'h14, {1'b0, i[2:0], 1'b0, i[2:0]});
            wr(8'h15, {4'h0, i[2:0], 1'b1});
            tk(1);
            chk({10'h0, l0_pct}, {10'h0, 6'(5 * i - 15)});
            chk({9'h0, emph_db}, {9'h0, EMPH[i * 7 +: 7]});
            chk({15'h0, emph_rsvd}, {15'h0, i == 3});
            chk(strength, 16'((17'h1 << (2 * i + 2)) - 1));
            chk({4'h0, l0_mv}, 16'h03E8);
        end
        chk({10'h0, clk_pct}, 16'h0014);
        lin = 1'b1;
        tk(1);
        chk({4'h0, clk_mv}, 16'h04B0);
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'h14, {5'h0, i[2:0]});
            chk({4'h0, l0_mv}, {4'h0, LIN_MV[(i > 3 ? 3 : i) * 12 +: 12]});
            chk({15'h0, l0_rsvd}, {15'h0, i > 3});
        end
        lin = 1'b0;
        lsel = 2'h1;
        tk(1);
        chk({15'h0, l0_glob}, 16'h0001);
        hra = 1'b1;
        tk(1);
        chk({15'h0, l0_glob}, 16'h0000);
        hsel = 2'h2;
        wr(8'h13, 8'h05);
        chk({12'h0, eq_app}, 16'h0000);
        chk({15'h0, eq_act}, 16'h0000);
        dpm = 1'b1;
        tk(1);
        chk({15'h0, l0_glob}, 16'h0001);
        chk({12'h0, eq_app}, 16'h0005);
        chk({15'h0, eq_act}, 16'h0001);
        // reset in mid-run must bring registers 14h, 12h and 13h back to their reset values
        reset_n = 1'b0;
        tk(2);
        reset_n = 1'b1;
        tk(1);
        rd(8'h14, 8'h03);
        rd(8'h12, 8'h03);
        rd(8'h13, 8'h00);
        conclude;
    end
endmodule // tb
bind lsecr_lane_cfg lsecr_lane_cfg_assertions lsecr_lane_cfg_assertions_i (.clk(clk),
    .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_hit_q(reg_hit_q),
    .linear_operation_select(linear_operation_select), .displayport_mode(displayport_mode),
    .clock_lane_equalizer_code(clock_lane_equalizer_code),
    .lane0_emphasis_code(lane0_emphasis_code), .lane0_swing_code(lane0_swing_code),
    .clock_lane_eq_applied_q(clock_lane_eq_applied_q),
    .lane0_emphasis_reserved_q(lane0_emphasis_reserved_q),
    .lane0_swing_reserved(lane0_swing_reserved));
